// *** core/bsa_pkg.sv ***
// shared constants for the block-transfer setup and address state
// assumes one engine clock; registers are loaded from the command stream
package bsa_pkg;
    // ************************************************************
    // register selects on the command load port
    // ************************************************************
    localparam logic [2:0] SEL_BACK = 3'h0;
    localparam logic [2:0] SEL_FORE = 3'h1;
    localparam logic [2:0] SEL_PAT = 3'h2;
    localparam logic [2:0] SEL_DEST = 3'h3;
    localparam logic [2:0] SEL_SPITCH = 3'h4;
    localparam logic [2:0] SEL_SRC = 3'h5;
    localparam logic [2:0] SEL_RCTL = 3'h6;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ADDR_MSB = 28;
    localparam int PAT_LSB = 6;
    localparam int SOLID_BIT = 31;
    localparam int DEPTH_MSB = 25;
    localparam int DEPTH_LSB = 24;
    localparam int ROP_MSB = 23;
    localparam int ROP_LSB = 16;
    localparam int PITCH_MSB = 15;
    localparam int QW_OFS_MSB = 2;
    // ************************************************************
    // encodings and reset values
    // ************************************************************
    localparam logic [1:0] DEPTH_8 = 2'h0;
    localparam logic [1:0] DEPTH_16 = 2'h1;
    localparam logic [1:0] DEPTH_16B = 2'h2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {
        CMD_PIXEL = 3'h0,
        CMD_ROW = 3'h1,
        CMD_GLYPH = 3'h2,
        CMD_FILL = 3'h3,
        CMD_COPY = 3'h4
    } bsa_cmd_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } bsa_state_type;
endpackage

// *** core/bsa_core.sv ***
// setup colours, addresses, pitches and raster control of a block-transfer engine
// assumes the command feeder loads one register per cycle and writes the
// destination address last; the walker steps lines via LINE_STEP
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: background colour expands zero bits for row/glyph
// RULE2: per-pixel draw uses background as solid pattern
// RULE3: foreground colour expands one bits for row/glyph
// RULE4: colour width follows depth: 32, 16, 8 bits
// RULE5: 23-bit pattern base, bits 28:6, row-draw only
// RULE6: pattern base low six bits read zero
// RULE7: issuer aligns colour pattern 64/128/256 bytes
// RULE8: issuer matches colour pattern depth to engine
// RULE9: monochrome pattern is 8 bytes in command
// RULE10: 29-bit destination doubles as working address
// RULE11: line start compared with clip top/bottom
// RULE12: destination write is last and starts execution
// RULE13: fill/copy destination is first byte written
// RULE14: issuer limits tiled destination base to 4KB
// RULE15: source pitch bytes, or doublewords when tiled
// RULE16: source address advances by signed pitch per line
// RULE17: 29-bit source, low 3 bits quadword offset
// RULE18: issuer limits tiled colour source to 4KB
// RULE19: solid select skips fetch, pattern becomes background
// RULE20: solid select honoured only for monochrome pattern
// RULE21: depth 00 is 8 bpp, 01 is 16 bpp
// RULE22: 8-bit raster code picks one of 256
// RULE23: destination advances by signed pitch per line
// RULE24: pixel is raster code applied bitwise
module bsa_core (
    input wire logic CLK, // engine clock
    input wire logic RESETN, // asynchronous reset, active low
    input wire logic LOAD_VALID, // command stream register load strobe
    input wire logic [2:0] LOAD_SEL, // which register is loaded
    input wire logic [31:0] LOAD_DATA, // value loaded
    input wire logic [2:0] CMD_KIND, // kind of drawing command
    input wire logic MONO_PAT, // opcode declares a monochrome pattern
    input wire logic [7:0] MONO_PAT_BYTE, // current row of in-command mono pattern
    input wire logic [2:0] PAT_BIT_IDX, // pixel column within pattern row
    input wire logic TILED, // surface tiled (pitch in doublewords)
    input wire logic [28:0] CLIP_TOP, // clip rectangle top line address
    input wire logic [28:0] CLIP_BOTTOM, // clip rectangle bottom line address
    input wire logic LINE_STEP, // walker finished one scan line
    input wire logic OP_END, // walker finished the operation
    input wire logic [31:0] PAT_FETCH, // colour pattern pixel from memory
    input wire logic [31:0] SRC_PIXEL, // source operand pixel
    input wire logic [31:0] DST_PIXEL, // existing destination pixel
    input wire logic [2:0] RD_SEL, // state readback select
    output logic BUSY, // operation in progress
    output logic START, // one-cycle start pulse
    output logic PAT_FETCH_EN, // pattern memory fetch needed
    output logic [28:0] PAT_ADDR, // pattern base for row draw
    output logic [28:0] DST_ADDR, // working destination address
    output logic [28:0] SRC_ADDR, // working source address
    output logic [2:0] SRC_QW_OFS, // first valid byte in first quadword
    output logic LINE_WRITE_OK, // high for non-line commands, else current line lies inside clip
    output logic [31:0] RESULT_PIXEL, // raster operation result
    output logic [31:0] RD_DATA // state readback
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        bsa_pkg::bsa_state_type st;
        logic [31:0] back;
        logic [31:0] fore;
        logic [22:0] pat;
        logic [28:0] dest;
        logic [15:0] spitch;
        logic [28:0] src;
        logic [31:0] rctl;
        logic start;
        logic [31:0] result;
    } bsa_regs_type;

    bsa_regs_type r_q;
    bsa_regs_type r_d;

    // trims a colour to the engine's pixel depth
    function automatic logic [31:0] depth_mask(input logic [1:0] depth, input logic [31:0] c);
        logic [31:0] m;
        m = c;
        if (depth == bsa_pkg::DEPTH_8) begin // [RULE21]
            m = {24'h00_0000, c[7:0]}; // [RULE4]
        end else if (depth == bsa_pkg::DEPTH_16 || depth == bsa_pkg::DEPTH_16B) begin
            m = {16'h0000, c[15:0]}; // [RULE4]
        end
        return m;
    endfunction

    // pitch in bytes; tiled pitch counts doublewords
    function automatic logic [28:0] pitch_bytes(input logic tiled, input logic [15:0] p);
        logic [28:0] b;
        b = {{13{p[15]}}, p};
        if (tiled) begin
            b = {b[26:0], 2'h0}; // [RULE15]
        end
        return b;
    endfunction

    logic [1:0] depth;
    logic [7:0] raster_operation_code;
    logic solid;
    logic mono_bit;
    logic [31:0] pat_op;
    logic [31:0] src_op;
    logic [31:0] dst_op;
    logic [31:0] res;

    assign depth = r_q.rctl[bsa_pkg::DEPTH_MSB:bsa_pkg::DEPTH_LSB];
    assign raster_operation_code = r_q.rctl[bsa_pkg::ROP_MSB:bsa_pkg::ROP_LSB]; // [RULE22]
    // solid select matters only for monochrome patterns
    assign solid = r_q.rctl[bsa_pkg::SOLID_BIT] && MONO_PAT; // [RULE20]
    // monochrome pattern bits come with the command, never from memory
    assign mono_bit = MONO_PAT_BYTE[PAT_BIT_IDX]; // [RULE9]

    // ************************************************************
    // operand selection and raster operation
    // ************************************************************
    always_comb begin
        pat_op = depth_mask(depth, PAT_FETCH);
        if (CMD_KIND == bsa_pkg::CMD_PIXEL) begin
            pat_op = depth_mask(depth, r_q.back); // [RULE2]
        end else if (solid) begin
            pat_op = depth_mask(depth, r_q.back); // [RULE19]
        end else if (MONO_PAT) begin
            if (mono_bit) begin
                pat_op = depth_mask(depth, r_q.fore); // [RULE3]
            end else begin
                pat_op = depth_mask(depth, r_q.back); // [RULE1]
            end
        end
        src_op = depth_mask(depth, SRC_PIXEL);
        dst_op = depth_mask(depth, DST_PIXEL);
        // bit index is {pattern, source, destination}
        for (int i = 0; i < 32; i++) begin
            res[i] = raster_operation_code[{pat_op[i], src_op[i], dst_op[i]}]; // [RULE24]
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        r_d = r_q;
        r_d.start = 1'b0;
        r_d.result = res;
        if (LOAD_VALID && r_q.st != bsa_pkg::ST_RUN) begin
            unique case (LOAD_SEL)
                bsa_pkg::SEL_BACK: begin
                    r_d.back = LOAD_DATA;
                end
                bsa_pkg::SEL_FORE: begin
                    r_d.fore = LOAD_DATA;
                end
                bsa_pkg::SEL_PAT: begin
                    r_d.pat = LOAD_DATA[bsa_pkg::ADDR_MSB:bsa_pkg::PAT_LSB]; // [RULE5]
                end
                bsa_pkg::SEL_DEST: begin
                    r_d.dest = LOAD_DATA[bsa_pkg::ADDR_MSB:0]; // [RULE10]
                    r_d.start = 1'b1; // [RULE12]
                    r_d.st = bsa_pkg::ST_RUN;
                end
                bsa_pkg::SEL_SPITCH: begin
                    r_d.spitch = LOAD_DATA[bsa_pkg::PITCH_MSB:0];
                end
                bsa_pkg::SEL_SRC: begin
                    r_d.src = LOAD_DATA[bsa_pkg::ADDR_MSB:0]; // [RULE17]
                end
                bsa_pkg::SEL_RCTL: begin
                    r_d.rctl = LOAD_DATA;
                end
                default: begin
                end
            endcase
        end
        unique case (r_q.st)
            bsa_pkg::ST_IDLE: begin
            end
            bsa_pkg::ST_RUN: begin
                if (LINE_STEP) begin
                    // working addresses move on to the next scan line
                    r_d.dest = r_q.dest + pitch_bytes(TILED, r_q.rctl[bsa_pkg::PITCH_MSB:0]); // [RULE23]
                    r_d.src = r_q.src + pitch_bytes(TILED, r_q.spitch); // [RULE16]
                end
                if (OP_END) begin
                    r_d.st = bsa_pkg::ST_DONE;
                end
            end
            bsa_pkg::ST_DONE: begin
                // a destination load in this cycle has already moved the state on
                if (!r_d.start) begin
                    r_d.st = bsa_pkg::ST_IDLE;
                end
            end
            default: begin
                r_d.st = bsa_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            r_q.st <= bsa_pkg::ST_IDLE;
            r_q.back <= bsa_pkg::REG_RESET;
            r_q.fore <= bsa_pkg::REG_RESET;
            r_q.pat <= '0;
            r_q.dest <= '0;
            r_q.spitch <= '0;
            r_q.src <= '0;
            r_q.rctl <= bsa_pkg::REG_RESET;
            r_q.start <= 1'b0;
            r_q.result <= bsa_pkg::REG_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic line_cmd;
    assign line_cmd = CMD_KIND == bsa_pkg::CMD_PIXEL || CMD_KIND == bsa_pkg::CMD_ROW
        || CMD_KIND == bsa_pkg::CMD_GLYPH;

    assign BUSY = r_q.st == bsa_pkg::ST_RUN;
    assign START = r_q.start;
    assign PAT_FETCH_EN = BUSY && !MONO_PAT && !solid && CMD_KIND != bsa_pkg::CMD_PIXEL; // [RULE19]
    // pattern base is only offered to row-draw commands
    assign PAT_ADDR = (CMD_KIND == bsa_pkg::CMD_ROW) ? {r_q.pat, 6'h00} : 29'h0000_0000; // [RULE5]
    // fill/copy: first byte written; line commands: scan-line start
    assign DST_ADDR = r_q.dest; // [RULE13]
    assign SRC_ADDR = r_q.src;
    assign SRC_QW_OFS = r_q.src[bsa_pkg::QW_OFS_MSB:0]; // [RULE17]
    assign LINE_WRITE_OK = !line_cmd || (r_q.dest >= CLIP_TOP && r_q.dest <= CLIP_BOTTOM); // [RULE11]
    assign RESULT_PIXEL = r_q.result;

    always_comb begin
        unique case (RD_SEL)
            bsa_pkg::SEL_BACK: RD_DATA = r_q.back;
            bsa_pkg::SEL_FORE: RD_DATA = r_q.fore;
            bsa_pkg::SEL_PAT: RD_DATA = {3'h0, r_q.pat, 6'h00}; // [RULE6]
            bsa_pkg::SEL_DEST: RD_DATA = {3'h0, r_q.dest};
            default: RD_DATA = 32'h0000_0000;
        endcase
    end
endmodule // bsa_core

// *** verification/bsa_sva.sv ***
// checker for the setup and address state block
// sees only the top ports; bound from the testbench top file
`timescale 1ns/10ps
module bsa_sva (
    input wire logic CLK, // clock
    input wire logic RESETN, // reset
    input wire logic LOAD_VALID, // load strobe
    input wire logic [2:0] LOAD_SEL, // load target
    input wire logic [31:0] LOAD_DATA, // load value
    input wire logic [2:0] CMD_KIND, // command kind
    input wire logic MONO_PAT, // mono pattern
    input wire logic TILED, // tiled pitch
    input wire logic [28:0] CLIP_TOP, // clip top
    input wire logic [28:0] CLIP_BOTTOM, // clip bottom
    input wire logic LINE_STEP, // line done
    input wire logic OP_END, // op done
    input wire logic [2:0] RD_SEL, // read select
    input wire logic BUSY, // busy
    input wire logic START, // start pulse
    input wire logic PAT_FETCH_EN, // fetch enable
    input wire logic [28:0] PAT_ADDR, // pattern base
    input wire logic [28:0] DST_ADDR, // dest address
    input wire logic LINE_WRITE_OK, // line in clip
    input wire logic [31:0] RD_DATA // readback
);
    // ************************************************************
    // shadow of the write-only raster control word
    // ************************************************************
    logic [31:0] rctl_q;
    logic dload;
    logic [28:0] dnext;
    assign dload = LOAD_VALID && !BUSY && LOAD_SEL == bsa_pkg::SEL_DEST;
    assign dnext = DST_ADDR + (TILED ? {{11{rctl_q[15]}}, rctl_q[15:0], 2'h0} : {{13{rctl_q[15]}}, rctl_q[15:0]});
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rctl_q <= 32'h0;
        end else if (LOAD_VALID && !BUSY && LOAD_SEL == bsa_pkg::SEL_RCTL) begin
            rctl_q <= LOAD_DATA;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    dst_load_a: assert property (dload |=> START && BUSY && DST_ADDR == 29'($past(LOAD_DATA)))
        else $error("destination load did not start the engine");
    start_cause_a: assert property (START |-> $past(dload) ##1 !START)
        else $error("start pulse without destination load");
    busy_end_a: assert property (BUSY && OP_END |=> !BUSY)
        else $error("busy after end of operation");
    dst_step_a: assert property (BUSY && LINE_STEP && !OP_END |=> DST_ADDR == $past(dnext))
        else $error("destination did not advance by pitch");
    dst_hold_a: assert property (BUSY && !LINE_STEP |=> $stable(DST_ADDR))
        else $error("working destination moved without a line step");
    pat_low_zero_a: assert property (RD_SEL == bsa_pkg::SEL_PAT |-> RD_DATA[5:0] == 6'h0)
        else $error("pattern base low bits not zero");
    pat_row_only_a:
        assert property (RD_SEL == bsa_pkg::SEL_PAT
            |-> PAT_ADDR == (CMD_KIND == bsa_pkg::CMD_ROW ? RD_DATA[28:0] : 29'h0))
        else $error("pattern base offered outside row draw");
    clip_a:
        assert property (LINE_WRITE_OK == (CMD_KIND >= bsa_pkg::CMD_FILL
            || (DST_ADDR >= CLIP_TOP && DST_ADDR <= CLIP_BOTTOM)))
        else $error("line write enable disagrees with clip");
    solid_fetch_a: assert property (MONO_PAT && rctl_q[31] |-> !PAT_FETCH_EN)
        else $error("pattern fetched with solid select");
    back_to_back_c: cover property (dload ##1 LOAD_VALID && BUSY);
    tiled_step_c: cover property (BUSY && LINE_STEP && TILED);
    solid_mono_c: cover property (MONO_PAT && rctl_q[31]);
endmodule // bsa_sva

// *** verification/bsa_mem.sv ***
// graphics memory model answering pattern, source and destination reads
// contents are a fixed function of address and a salt set by the bench
`timescale 1ns/10ps
module bsa_mem (
    input wire logic [31:0] salt, // content scramble
    input wire logic [28:0] pat_addr, // pattern address
    input wire logic [28:0] src_addr, // source address
    input wire logic [28:0] dst_addr, // dest address
    output logic [31:0] pat_word, // pattern pixel
    output logic [31:0] src_word, // source pixel
    output logic [31:0] dst_word // dest pixel
);
    // colour pattern stored at its aligned base, engine depth
    assign pat_word = {pat_addr, 3'h0} ^ salt;
    assign src_word = {src_addr, 3'h1} ^ salt;
    assign dst_word = {dst_addr, 3'h2} ^ salt;
endmodule // bsa_mem

// *** verification/tb_bsa_core.sv ***
// self-checking bench for the setup and address state block
// inputs change at the falling edge; the memory model supplies operands
`timescale 1ns/10ps
module tb_bsa_core;
    logic CLK, RESETN, LOAD_VALID, MONO_PAT, TILED, LINE_STEP, OP_END, BUSY, START, PAT_FETCH_EN, LINE_WRITE_OK;
    logic [2:0] LOAD_SEL, CMD_KIND, PAT_BIT_IDX, RD_SEL, SRC_QW_OFS;
    logic [7:0] MONO_PAT_BYTE;
    logic [28:0] CLIP_TOP, CLIP_BOTTOM, PAT_ADDR, DST_ADDR, SRC_ADDR, de, se;
    logic [31:0] LOAD_DATA, PAT_FETCH, SRC_PIXEL, DST_PIXEL, RESULT_PIXEL, RD_DATA, salt, bk, fg, pb, rc, sp, m, pf;
    logic [31:0] rb[8];
    logic [31:0] ex;
    int n_mismatch = 0;
    int n_checks = 0;
    bsa_core bsa_core_i (.CLK, .RESETN, .LOAD_VALID, .LOAD_SEL, .LOAD_DATA, .CMD_KIND, .MONO_PAT, .MONO_PAT_BYTE,
        .PAT_BIT_IDX, .TILED, .CLIP_TOP, .CLIP_BOTTOM, .LINE_STEP, .OP_END, .PAT_FETCH, .SRC_PIXEL, .DST_PIXEL,
        .RD_SEL, .BUSY, .START, .PAT_FETCH_EN, .PAT_ADDR, .DST_ADDR, .SRC_ADDR, .SRC_QW_OFS, .LINE_WRITE_OK,
        .RESULT_PIXEL, .RD_DATA);
    bsa_mem bsa_mem_i (.salt, .pat_addr(PAT_ADDR), .src_addr(SRC_ADDR), .dst_addr(DST_ADDR), .pat_word(PAT_FETCH),
        .src_word(SRC_PIXEL), .dst_word(DST_PIXEL));
    function automatic logic [31:0] mem(input logic [28:0] a, input logic [2:0] k);
        return {a, k} ^ salt;
    endfunction
    function automatic logic [28:0] step(input logic [15:0] p);
        return TILED ? {{11{p[15]}}, p, 2'h0} : {{13{p[15]}}, p};
    endfunction
    function automatic logic [31:0] pix(input logic [31:0] pt, s, d);
        logic [31:0] p;
        logic [31:0] r;
        p = MONO_PAT ? (MONO_PAT_BYTE[PAT_BIT_IDX] ? fg : bk) : pt;
        if (CMD_KIND == bsa_pkg::CMD_PIXEL || (MONO_PAT && rc[31])) p = bk;
        for (int i = 0; i < 32; i++) r[i] = rc[16 + {p[i], s[i], d[i]}];
        return r & m;
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ld(input logic [2:0] sel, input logic [31:0] d);
        @(negedge CLK);
        LOAD_VALID = 1'b1;
        LOAD_SEL = sel;
        LOAD_DATA = d;
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        final_report();
    end
    initial begin
        {RESETN, LOAD_VALID, MONO_PAT, TILED, LINE_STEP, OP_END, LOAD_SEL, CMD_KIND, PAT_BIT_IDX, RD_SEL} = '0;
        {MONO_PAT_BYTE, CLIP_TOP, CLIP_BOTTOM, LOAD_DATA, salt} = '0;
        void'($urandom(32'h51237CDA));
        repeat (6) @(negedge CLK);
        RESETN = 1'b1;
        for (int it = 0; it < 24; it++) begin
            {salt, bk, fg, rc, sp} = {$urandom, $urandom, $urandom, $urandom, $urandom};
            rc[25:24] = it[1:0];
            m = rc[25:24] == 2'h0 ? 32'hFF : (rc[25:24] == 2'h3 ? 32'hFFFF_FFFF : 32'hFFFF);
            pb = it[2] ? $urandom : $urandom & 32'h1FFF_FF00;
            de = 29'($urandom & 32'hFFF);
            se = 29'($urandom & 32'hFFF);
            CLIP_TOP = 29'($urandom & 32'hFFF);
            CLIP_BOTTOM = 29'($urandom & 32'hFFF);
            TILED = 1'($urandom);
            ld(bsa_pkg::SEL_BACK, bk);
            ld(bsa_pkg::SEL_FORE, fg);
            ld(bsa_pkg::SEL_PAT, pb);
            ld(bsa_pkg::SEL_SPITCH, sp);
            ld(bsa_pkg::SEL_SRC, {3'($urandom), se});
            ld(bsa_pkg::SEL_RCTL, rc);
            ld(bsa_pkg::SEL_DEST, {3'h5, de});
            ld(bsa_pkg::SEL_BACK, ~bk);
            @(negedge CLK);
            LOAD_VALID = 1'b0;
            rb = '{bk, fg, pb & 32'h1FFF_FFC0, {3'h0, de}, 32'h0, 32'h0, 32'h0, 32'h0};
            for (int r = 0; r < 8; r++) begin
                RD_SEL = 3'(r);
                #1 chk(RD_DATA, rb[r]);
                @(negedge CLK);
            end
            for (int k = 0; k < 10; k++) begin
                CMD_KIND = 3'(k / 2);
                MONO_PAT = k[0];
                MONO_PAT_BYTE = 8'($urandom);
                PAT_BIT_IDX = 3'($urandom);
                pf = mem(CMD_KIND == bsa_pkg::CMD_ROW ? {pb[28:6], 6'h0} : 29'h0, 3'h0);
                @(negedge CLK);
                ex = pix(pf, mem(se, 3'h1), mem(de, 3'h2));
                chk(RESULT_PIXEL & m, ex);
                ex = 32'(CMD_KIND >= bsa_pkg::CMD_FILL || (de >= CLIP_TOP && de <= CLIP_BOTTOM));
                chk({31'h0, LINE_WRITE_OK}, ex);
                ex = 32'(!MONO_PAT && CMD_KIND != bsa_pkg::CMD_PIXEL);
                chk({31'h0, PAT_FETCH_EN}, ex);
                ex = CMD_KIND == bsa_pkg::CMD_ROW ? pb & 32'h1FFF_FFC0 : 32'h0;
                chk({3'h0, PAT_ADDR}, ex);
            end
            LINE_STEP = 1'b1;
            repeat (3) begin
                @(negedge CLK);
                de = de + step(rc[15:0]);
                se = se + step(sp[15:0]);
            end
            LINE_STEP = 1'b0;
            OP_END = 1'b1;
            @(negedge CLK);
            OP_END = 1'b0;
            chk({3'h0, DST_ADDR}, {3'h0, de});
            chk({3'h0, SRC_ADDR}, {3'h0, se});
            chk({29'h0, SRC_QW_OFS}, {29'h0, se[2:0]});
            chk({31'h0, BUSY}, 32'h0);
            if (it[0]) begin
                // a destination load in the done cycle right after an operation starts a new one
                LOAD_VALID = 1'b1;
                LOAD_SEL = bsa_pkg::SEL_DEST;
                LOAD_DATA = {3'h0, de};
                @(negedge CLK);
                LOAD_VALID = 1'b0;
                chk({31'h0, BUSY}, 32'h1);
                chk({3'h0, DST_ADDR}, {3'h0, de});
                OP_END = 1'b1;
                @(negedge CLK);
                OP_END = 1'b0;
            end
        end
        final_report();
    end
endmodule // tb_bsa_core
bind bsa_core bsa_sva bsa_sva_i (.CLK, .RESETN, .LOAD_VALID, .LOAD_SEL, .LOAD_DATA, .CMD_KIND, .MONO_PAT, .TILED,
    .CLIP_TOP, .CLIP_BOTTOM, .LINE_STEP, .OP_END, .RD_SEL, .BUSY, .START, .PAT_FETCH_EN, .PAT_ADDR, .DST_ADDR,
    .LINE_WRITE_OK, .RD_DATA);
